// >>> common/octal_parity_pkg.sv
// Constants and types for the octal link parity and reset block
package octal_parity_pkg;

	// Configuration register two addresses and fields
	localparam logic [31:0] CFG2_PARITY_ADDR = 32'h40000000;
	localparam int PARITY_EN_BIT = 3;
	localparam logic [31:0] CFG2_CHECK_ADDR = 32'h00000500;
	localparam int CHUNK_SEL_LSB = 0;
	localparam int CHECK_INV_BIT = 2;

	// Values after reset
	localparam logic PARITY_EN_N_RST = 1'b1;
	localparam logic [1:0] CHUNK_SEL_RST = 2'h0;
	localparam logic CHECK_INV_RST = 1'b0;

	// Frame layout in byte slots
	localparam logic [2:0] CMD_LAST_DTR = 3'h1;
	localparam logic [2:0] CMD_LAST_STR = 3'h0;
	localparam logic [2:0] ADDR_LAST = 3'h3;
	localparam logic [2:0] CHECK_LAST = 3'h1;

	// Chunk of 16 bytes, doubled per step of the size field
	localparam logic [7:0] CHUNK_BASE_LAST = 8'h0F;

	typedef enum logic [1:0] {
		OP_ARRAY_WRITE,
		OP_ARRAY_READ,
		OP_REG_WRITE,
		OP_REG_READ
	} opKind_e;

	// Pins seen from the device, all outside the clock domain
	typedef struct packed {
		logic sclk;
		logic csN;
		logic resetN;
		logic [7:0] data;
	} linkIn_s;

	// Configuration register write
	typedef struct packed {
		logic stb;
		logic [31:0] addr;
		logic [7:0] data;
	} cfgWrite_s;

endpackage

// >>> rtl/octal_parity_reset.sv
// Transfer parity check and reset handling of a single- and double-rate octal flash interface
`timescale 1ns/1ps
module octal_parity_reset
	import octal_parity_pkg::*;
(
	// Clock and supply-level reset
	input wire logic clk,
	input wire logic rst,
	// Link pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic resetPinN,
	input wire logic [7:0] octalIn,
	output logic [7:0] octalOut,
	output logic octalOe,
	// Mode and one-time parity cell
	input wire logic dtrMode,
	input wire logic otpParityN,
	output logic otpProgram,
	output logic parityActive,
	// Configuration writes and command kind
	input wire cfgWrite_s cfgWrite,
	input wire opKind_e opKind,
	// Array and register data
	output logic [7:0] progByte,
	output logic progByteStb,
	output logic progCommit,
	output logic progAbort,
	input wire logic [7:0] readData,
	output logic readNext,
	input wire logic [7:0] regReadData,
	output logic [7:0] regWriteData,
	output logic regWriteStb,
	// Status and reset effects
	input wire logic welSet,
	input wire logic welClr,
	input wire logic wipSet,
	input wire logic wipClr,
	output logic write_enable_latch_bit,
	output logic write_in_progress_bit,
	output logic opTerminate,
	output logic fastBootStart
);

	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_ACHK, PH_DATA, PH_DCHK, PH_REGINV,
		PH_DONE} phase_e;

	linkIn_s pinNow, s1_r, s2_r, s3_r, pin_r, pinNxt;
	logic sclkEdge, sclkRise, csFall, csRise, byteTake, pinReset, isRead;
	logic parityEnN_r, otpLoaded_r, chunkInv_r, frameParity_r, frameDtr_r, bad_r;
	logic [1:0] chunkSel_r;
	logic [7:0] chunkLast_r, chunkCnt_r, addrXor_r, dataXor_r, regData_r, rxByte, chunkLastNow;
	logic [31:0] addr_r;
	logic [2:0] cnt_r;
	logic fastBootPend_r;
	opKind_e kind_r;
	phase_e phase_r;

	assign pinNow = '{sclk: sclk, csN: csN, resetN: resetPinN, data: octalIn};

	// Three-stage sampling; a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= '{sclk: 1'b0, csN: 1'b1, resetN: 1'b1, data: 8'h00};
			s2_r <= '{sclk: 1'b0, csN: 1'b1, resetN: 1'b1, data: 8'h00};
			s3_r <= '{sclk: 1'b0, csN: 1'b1, resetN: 1'b1, data: 8'h00};
			pin_r <= '{sclk: 1'b0, csN: 1'b1, resetN: 1'b1, data: 8'h00};
		end else begin
			s1_r <= pinNow;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_r <= pinNxt;
		end
	end

	for (genvar gi = 0; gi < $bits(linkIn_s); gi++) begin : gFilter
		assign pinNxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : pin_r[gi];
	end

	assign sclkEdge = pinNxt.sclk != pin_r.sclk;
	assign sclkRise = sclkEdge & pinNxt.sclk;
	assign csFall = pin_r.csN & ~pinNxt.csN;
	assign csRise = ~pin_r.csN & pinNxt.csN;
	assign pinReset = ~pin_r.resetN;
	assign rxByte = pinNxt.data;
	// Single-rate frames use rising edges only
	assign byteTake = ~pin_r.csN & ~pinNxt.csN & ~pinReset & ~csFall
		& (sclkRise | (sclkEdge & frameDtr_r));
	assign isRead = (kind_r == OP_ARRAY_READ) || (kind_r == OP_REG_READ);
	assign chunkLastNow = ((CHUNK_BASE_LAST + 8'h01) << chunkSel_r) - 8'h01;
	assign parityActive = dtrMode & ~parityEnN_r;

	// One-time parity cell: loaded after release, only ever cleared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			parityEnN_r <= PARITY_EN_N_RST;
			otpLoaded_r <= 1'b0;
			otpProgram <= 1'b0;
		end else begin
			otpLoaded_r <= 1'b1;
			otpProgram <= 1'b0;
			if (!otpLoaded_r) begin
				parityEnN_r <= otpParityN;
			end else if (cfgWrite.stb && !pinReset && cfgWrite.addr == CFG2_PARITY_ADDR
				&& !cfgWrite.data[PARITY_EN_BIT] && parityEnN_r) begin
				parityEnN_r <= 1'b0;
				otpProgram <= 1'b1;
			end
		end
	end

	// Volatile check settings return to defaults on either reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chunkSel_r <= CHUNK_SEL_RST;
			chunkInv_r <= CHECK_INV_RST;
		end else if (pinReset) begin
			chunkSel_r <= CHUNK_SEL_RST;
			chunkInv_r <= CHECK_INV_RST;
		end else if (cfgWrite.stb && cfgWrite.addr == CFG2_CHECK_ADDR) begin
			chunkSel_r <= cfgWrite.data[CHUNK_SEL_LSB +: 2];
			chunkInv_r <= cfgWrite.data[CHECK_INV_BIT];
		end
	end

	// Write latch and busy: set wins over clear, both cleared by resets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			write_enable_latch_bit <= 1'b0;
			write_in_progress_bit <= 1'b0;
		end else if (pinReset) begin
			write_enable_latch_bit <= 1'b0;
			write_in_progress_bit <= 1'b0;
		end else begin
			write_enable_latch_bit <= welSet | (write_enable_latch_bit & ~welClr);
			write_in_progress_bit <= wipSet | (write_in_progress_bit & ~wipClr);
		end
	end

	// Reset pin side effects
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opTerminate <= 1'b0;
			fastBootStart <= 1'b0;
			fastBootPend_r <= 1'b0;
		end else begin
			opTerminate <= pin_r.resetN & ~pinNxt.resetN & write_in_progress_bit;
			fastBootStart <= 1'b0;
			if (pinReset) begin
				fastBootPend_r <= 1'b1;
			end else if (csFall && fastBootPend_r) begin
				fastBootPend_r <= 1'b0;
				fastBootStart <= 1'b1;
			end
		end
	end

	// Frame sequencer; dummy cycles are not modelled, data follows the address checks or, without parity, the address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= PH_IDLE;
			kind_r <= OP_ARRAY_WRITE;
			cnt_r <= 3'h0;
			frameParity_r <= 1'b0;
			frameDtr_r <= 1'b0;
			chunkLast_r <= CHUNK_BASE_LAST;
			chunkCnt_r <= 8'h00;
			addr_r <= 32'h0;
			addrXor_r <= 8'h00;
			dataXor_r <= 8'h00;
			regData_r <= 8'h00;
			bad_r <= 1'b0;
			octalOut <= 8'h00;
			octalOe <= 1'b0;
			progByte <= 8'h00;
			progByteStb <= 1'b0;
			progCommit <= 1'b0;
			progAbort <= 1'b0;
			readNext <= 1'b0;
			regWriteData <= 8'h00;
			regWriteStb <= 1'b0;
		end else begin
			progByteStb <= 1'b0;
			progCommit <= 1'b0;
			progAbort <= 1'b0;
			readNext <= 1'b0;
			regWriteStb <= 1'b0;
			if (pinReset) begin
				phase_r <= PH_IDLE;
				octalOe <= 1'b0;
			end else if (csFall) begin
				phase_r <= PH_CMD;
				kind_r <= opKind;
				cnt_r <= 3'h0;
				frameParity_r <= parityActive;
				frameDtr_r <= dtrMode;
				chunkLast_r <= chunkLastNow;
				chunkCnt_r <= 8'h00;
				addrXor_r <= 8'h00;
				bad_r <= 1'b0;
			end else if (csRise) begin
				phase_r <= PH_IDLE;
				octalOe <= 1'b0;
				if (kind_r == OP_ARRAY_WRITE && phase_r != PH_IDLE) begin
					// In a parity frame, an incomplete chunk or any mismatch refuses the program
					if (frameParity_r && (bad_r || phase_r != PH_DATA || chunkCnt_r != 8'h00)) begin
						progAbort <= 1'b1;
					end else begin
						progCommit <= 1'b1;
					end
				end
			end else if (byteTake) begin
				cnt_r <= cnt_r + 3'h1;
				unique case (phase_r)
					PH_IDLE, PH_DONE: begin
						cnt_r <= 3'h0;
					end
					PH_CMD: begin
						if (cnt_r == (frameDtr_r ? CMD_LAST_DTR : CMD_LAST_STR)) begin
							phase_r <= PH_ADDR;
							cnt_r <= 3'h0;
						end
					end
					PH_ADDR: begin
						addr_r <= {addr_r[23:0], rxByte};
						addrXor_r <= addrXor_r ^ rxByte;
						if (cnt_r == ADDR_LAST) begin
							cnt_r <= 3'h0;
							if (frameParity_r) begin
								phase_r <= PH_ACHK;
							end else begin
								phase_r <= PH_DATA;
								if (isRead) begin
									octalOe <= 1'b1;
									octalOut <= (kind_r == OP_REG_READ) ? regReadData : readData;
									regData_r <= regReadData;
									readNext <= kind_r == OP_ARRAY_READ;
								end
							end
						end
					end
					PH_ACHK: begin
						if (cnt_r == 3'h0 && rxByte != addrXor_r) begin
							bad_r <= 1'b1;
						end
						if (cnt_r == CHECK_LAST) begin
							cnt_r <= 3'h0;
							phase_r <= PH_DATA;
							if ((addr_r[7:0] & chunkLast_r) != 8'h00) begin
								bad_r <= 1'b1;
							end
							if (isRead) begin
								octalOe <= 1'b1;
								octalOut <= (kind_r == OP_REG_READ) ? regReadData : readData;
								regData_r <= regReadData;
								dataXor_r <= readData;
								readNext <= kind_r == OP_ARRAY_READ;
							end
						end
					end
					PH_DATA: begin
						unique case (kind_r)
							OP_ARRAY_WRITE: begin
								progByte <= rxByte;
								progByteStb <= 1'b1;
								dataXor_r <= (chunkCnt_r == 8'h00) ? rxByte : dataXor_r ^ rxByte;
								chunkCnt_r <= (chunkCnt_r == chunkLast_r) ? 8'h00 : chunkCnt_r + 8'h01;
								if (frameParity_r && chunkCnt_r == chunkLast_r) begin
									phase_r <= PH_DCHK;
									cnt_r <= 3'h0;
								end
							end
							OP_REG_WRITE: begin
								regData_r <= rxByte;
								phase_r <= frameParity_r ? PH_REGINV : PH_DONE;
								if (!frameParity_r) begin
									regWriteData <= rxByte;
									regWriteStb <= 1'b1;
								end
							end
							OP_REG_READ: begin
								if (frameParity_r) begin
									phase_r <= PH_REGINV;
									octalOut <= ~regData_r;
								end else begin
									phase_r <= PH_DONE;
									octalOe <= 1'b0;
								end
							end
							OP_ARRAY_READ: begin
								if (frameParity_r && chunkCnt_r == chunkLast_r) begin
									phase_r <= PH_DCHK;
									cnt_r <= 3'h0;
									chunkCnt_r <= 8'h00;
									octalOut <= dataXor_r;
								end else begin
									chunkCnt_r <= (chunkCnt_r == chunkLast_r) ? 8'h00 : chunkCnt_r + 8'h01;
									octalOut <= readData;
									dataXor_r <= dataXor_r ^ readData;
									readNext <= 1'b1;
								end
							end
						endcase
					end
					PH_DCHK: begin
						if (isRead) begin
							if (cnt_r == 3'h0) begin
								octalOut <= chunkInv_r ? ~dataXor_r : dataXor_r;
							end else begin
								phase_r <= PH_DATA;
								octalOut <= readData;
								dataXor_r <= readData;
								readNext <= 1'b1;
							end
						end else begin
							if (cnt_r == 3'h0 && rxByte != dataXor_r) begin
								bad_r <= 1'b1;
							end
							if (cnt_r == CHECK_LAST) begin
								phase_r <= PH_DATA;
							end
						end
					end
					PH_REGINV: begin
						phase_r <= PH_DONE;
						octalOe <= 1'b0;
						// Write lands only when its inverted copy agrees
						if (!isRead && rxByte == ~regData_r && !bad_r) begin
							regWriteData <= regData_r;
							regWriteStb <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	AST_STR_NO_PARITY: assert property (@(posedge clk) disable iff (rst)
		csFall && !pinReset && !dtrMode |=> !frameParity_r)
		else $error("Parity active in a single-rate frame");

	AST_OTP_WRITE: assert property (@(posedge clk) disable iff (rst)
		otpLoaded_r && cfgWrite.stb && !pinReset && cfgWrite.addr == CFG2_PARITY_ADDR
		&& !cfgWrite.data[PARITY_EN_BIT] |=> !parityEnN_r)
		else $error("Parity enable write of zero not taken");

	AST_OTP_STICKY: assert property (@(posedge clk) disable iff (rst)
		otpLoaded_r && !parityEnN_r |=> !parityEnN_r [*8])
		else $error("Parity enable returned to one");

	AST_HIZ_IN_RESET: assert property (@(posedge clk) disable iff (rst)
		pinReset |=> !octalOe)
		else $error("Data lines driven during pin reset");

	AST_RESET_DEFAULTS: assert property (@(posedge clk) disable iff (rst)
		pinReset |=> !write_enable_latch_bit && !write_in_progress_bit && chunkSel_r == CHUNK_SEL_RST && phase_r == PH_IDLE)
		else $error("Pin reset left volatile state set");

	AST_FAST_BOOT: assert property (@(posedge clk) disable iff (rst)
		csFall && !pinReset && fastBootPend_r |=> fastBootStart ##1 !fastBootStart)
		else $error("Fast boot not started on first select");

	AST_TERMINATE: assert property (@(posedge clk) disable iff (rst)
		write_in_progress_bit && pin_r.resetN && !pinNxt.resetN |=> opTerminate ##1 !write_in_progress_bit)
		else $error("Busy operation not terminated by pin reset");

	AST_PROG_ABORT: assert property (@(posedge clk) disable iff (rst)
		csRise && !pinReset && kind_r == OP_ARRAY_WRITE && frameParity_r && bad_r
		&& phase_r != PH_IDLE |=> progAbort && !progCommit)
		else $error("Faulty program not aborted");

	AST_ADDR_CHECK: assert property (@(posedge clk) disable iff (rst)
		byteTake && !csRise && phase_r == PH_ACHK && cnt_r == 3'h0 && rxByte != addrXor_r
		|=> bad_r)
		else $error("Address check mismatch not flagged");

	AST_REG_READ_INV: assert property (@(posedge clk) disable iff (rst)
		byteTake && !csRise && phase_r == PH_DATA && kind_r == OP_REG_READ && frameParity_r
		|=> octalOe && octalOut == ~$past(octalOut) && phase_r == PH_REGINV)
		else $error("Inverted register read cycle missing");

	AST_CHECK_FORM: assert property (@(posedge clk) disable iff (rst)
		byteTake && !csRise && phase_r == PH_DCHK && isRead && cnt_r == 3'h0
		|=> octalOut == (chunkInv_r ? ~$past(octalOut) : $past(octalOut)))
		else $error("Check byte output form wrong");

endmodule

// >>> verification/octal_host_model.sv
// Host controller model driving the octal link pins
`timescale 1ns/1ps
module octal_host_model (
	// Clock
	input wire logic clk,
	// Link pins
	output logic sclk,
	output logic csN,
	output logic resetPinN,
	output logic [7:0] hostData,
	output logic hostOe,
	input wire logic [7:0] octalWire
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		resetPinN = 1'b1;
		hostData = 8'h00;
		hostOe = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic select();
		waitClk(4);
		csN = 1'b0;
		waitClk(4);
	endtask
	// Data moves midway between link edges so it is held around each edge
	task automatic put(input logic [7:0] b);
		hostOe = 1'b1;
		hostData = b;
		waitClk(2);
		sclk = ~sclk;
		waitClk(2);
	endtask
	task automatic get(output logic [7:0] b);
		hostOe = 1'b0;
		waitClk(4);
		b = octalWire;
		sclk = ~sclk;
	endtask
	// Released lines show the inverse of the last byte, never a stale copy
	task automatic deselect();
		hostOe = 1'b0;
		waitClk(4);
		csN = 1'b1;
		waitClk(8);
	endtask
	task automatic header(input logic [31:0] a, input logic [7:0] flip);
		logic [7:0] x;
		x = a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0];
		put(8'hEE);
		put(8'h11);
		for (int i = 3; i >= 0; i--) put(a[i * 8 +: 8]);
		put(x ^ flip);
		put(x);
	endtask
	// Select stays low a while, so only reset can release the lines
	task automatic resetLow();
		resetPinN = 1'b0;
		hostOe = 1'b0;
		waitClk(6);
		csN = 1'b1;
		sclk = 1'b0;
	endtask
	// Recovery sized for an interrupted program, the longest case used
	task automatic resetHigh();
		waitClk(190);
		resetPinN = 1'b1;
		waitClk(6200);
	endtask
endmodule

// >>> verification/test_octal_parity_reset.sv
// Self-checking bench for the octal parity and reset block
`timescale 1ns/1ps
module test_octal_parity_reset;
	import octal_parity_pkg::*;
	logic clk, rst, dtrMode, otpParityN, welSet, welClr, wipSet, wipClr;
	logic [7:0] readData, regReadData, octalOut, progByte, regWriteData, lastReg, b, c;
	logic sclk, csN, resetPinN, hostOe, octalOe, otpProgram, parityActive;
	logic progByteStb, progCommit, progAbort, readNext, regWriteStb, write_enable_latch_bit, write_in_progress_bit;
	logic opTerminate, fastBootStart;
	logic [7:0] hostData, octalWire;
	logic [7:0] nStb = 8'h00, nCommit = 8'h00, nAbort = 8'h00, nOtp = 8'h00;
	logic [7:0] nTerm = 8'h00, nBoot = 8'h00;
	logic [7:0] nProg = 8'h00, pXor = 8'h00;
	cfgWrite_s cfgWrite;
	opKind_e opKind;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	assign octalWire = octalOe ? octalOut : (hostOe ? hostData : ~hostData);
	octal_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .resetPinN(resetPinN),
		.hostData(hostData), .hostOe(hostOe), .octalWire(octalWire));
	octal_parity_reset dut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
		.resetPinN(resetPinN), .octalIn(octalWire), .octalOut(octalOut), .octalOe(octalOe),
		.dtrMode(dtrMode), .otpParityN(otpParityN), .otpProgram(otpProgram),
		.parityActive(parityActive), .cfgWrite(cfgWrite), .opKind(opKind),
		.progByte(progByte), .progByteStb(progByteStb), .progCommit(progCommit),
		.progAbort(progAbort), .readData(readData), .readNext(readNext),
		.regReadData(regReadData), .regWriteData(regWriteData), .regWriteStb(regWriteStb),
		.welSet(welSet), .welClr(welClr), .wipSet(wipSet), .wipClr(wipClr), .write_enable_latch_bit(write_enable_latch_bit),
		.write_in_progress_bit(write_in_progress_bit), .opTerminate(opTerminate), .fastBootStart(fastBootStart));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Pulses last one cycle, so they are counted rather than polled
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (regWriteStb) lastReg <= regWriteData;
		nStb <= nStb + 8'(regWriteStb);
		nCommit <= nCommit + 8'(progCommit);
		nAbort <= nAbort + 8'(progAbort);
		nOtp <= nOtp + 8'(otpProgram);
		nTerm <= nTerm + 8'(opTerminate);
		nBoot <= nBoot + 8'(fastBootStart);
		nProg <= nProg + 8'(progByteStb);
		if (progByteStb) pXor <= pXor ^ progByte;
		if (cycles == 30000) begin
			n_errors++;
			end_sim();
		end
	end
	// Cell model: a burn request sticks across later power cycles
	always @(negedge clk) begin
		if (readNext) readData <= readData + 8'h01;
		if (otpProgram) otpParityN <= 1'b0;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic cfg(input logic [31:0] a, input logic [7:0] d);
		cfgWrite = '{1'b1, a, d};
		@(negedge clk);
		cfgWrite.stb = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic regWrite(input logic [7:0] flip, input logic [7:0] d, input logic [7:0] e);
		opKind = OP_REG_WRITE;
		host.select();
		host.header(32'h00000200, flip);
		host.put(d);
		host.put(e);
		host.deselect();
	endtask
	task automatic arrWrite(input logic [31:0] a, input int n, input logic [7:0] f,
		input logic ok);
		logic [7:0] x, c0, a0, p0, q0;
		x = 8'h00;
		c0 = nCommit;
		a0 = nAbort;
		p0 = nProg;
		q0 = pXor;
		opKind = OP_ARRAY_WRITE;
		host.select();
		host.header(a, 8'h00);
		for (int i = 0; i < n; i++) begin
			host.put(8'(i * 7 + 1));
			x ^= 8'(i * 7 + 1);
		end
		host.put(x ^ f);
		host.put(x);
		host.deselect();
		chk("commit", c0 + 8'(ok), nCommit);
		chk("abort", a0 + 8'(!ok), nAbort);
		if (ok) begin
			chk("progCnt", p0 + 8'(n), nProg);
			chk("progXor", q0 ^ x, pXor);
		end
	endtask
	initial begin
		logic [7:0] x;
		rst = 1'b1;
		dtrMode = 1'b1;
		otpParityN = 1'b1;
		{welSet, welClr, wipSet, wipClr} = 4'h0;
		readData = 8'h00;
		regReadData = 8'h3C;
		cfgWrite = '0;
		opKind = OP_ARRAY_READ;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk("wel", 8'h00, 8'(write_enable_latch_bit));
		chk("oe", 8'h00, 8'(octalOe));
		chk("active", 8'h00, 8'(parityActive));
		$display("test power_on done");
		cfg(CFG2_PARITY_ADDR, 8'hF7);
		chk("otp", 8'h01, nOtp);
		chk("active", 8'h01, 8'(parityActive));
		dtrMode = 1'b0;
		@(negedge clk);
		chk("active", 8'h00, 8'(parityActive));
		dtrMode = 1'b1;
		cfg(CFG2_PARITY_ADDR, 8'hFF);
		chk("active", 8'h01, 8'(parityActive));
		chk("otp", 8'h01, nOtp);
		$display("test enable done");
		regWrite(8'h00, 8'h5A, 8'hA5);
		chk("regStb", 8'h01, nStb);
		chk("regData", 8'h5A, lastReg);
		regWrite(8'h01, 8'h66, 8'h99);
		regWrite(8'h00, 8'h66, 8'h66);
		chk("regStb", 8'h01, nStb);
		opKind = OP_REG_READ;
		host.select();
		host.header(32'h00000200, 8'h00);
		host.get(b);
		host.get(c);
		host.deselect();
		chk("regRd", 8'h3C, b);
		chk("regRdInv", 8'hC3, c);
		dtrMode = 1'b0;
		opKind = OP_REG_WRITE;
		host.select();
		for (int i = 0; i < 12; i++) host.put((i < 10) ? 8'h00 : 8'h3D);
		host.deselect();
		dtrMode = 1'b1;
		chk("strStb", 8'h02, nStb);
		chk("strData", 8'h3D, lastReg);
		$display("test register done");
		arrWrite(32'h00000100, 16, 8'h00, 1'b1);
		arrWrite(32'h00000100, 16, 8'h40, 1'b0);
		arrWrite(32'h00000104, 16, 8'h00, 1'b0);
		cfg(CFG2_CHECK_ADDR, 8'h01);
		arrWrite(32'h00000100, 32, 8'h00, 1'b1);
		arrWrite(32'h00000100, 16, 8'h00, 1'b0);
		cfg(CFG2_CHECK_ADDR, 8'h02);
		arrWrite(32'h00000140, 64, 8'h00, 1'b1);
		cfg(CFG2_CHECK_ADDR, 8'h03);
		arrWrite(32'h00000100, 128, 8'h00, 1'b1);
		arrWrite(32'h00000140, 128, 8'h00, 1'b0);
		$display("test array write done");
		for (int f = 0; f < 2; f++) begin
			cfg(CFG2_CHECK_ADDR, 8'(f * 4));
			readData = 8'h10;
			x = 8'h00;
			opKind = OP_ARRAY_READ;
			host.select();
			host.header(32'h00000100, 8'h00);
			for (int i = 0; i < 16; i++) begin
				host.get(b);
				chk("rdData", 8'(8'h10 + i), b);
				x ^= 8'(8'h10 + i);
			end
			host.get(b);
			host.get(c);
			host.deselect();
			chk("rdCheck", x, b);
			chk("rdCheck2", f ? ~x : x, c);
		end
		$display("test array read done");
		welSet = 1'b1;
		welClr = 1'b1;
		wipSet = 1'b1;
		@(negedge clk);
		{welSet, welClr, wipSet} = 3'h0;
		@(negedge clk);
		chk("wel", 8'h01, 8'(write_enable_latch_bit));
		chk("wip", 8'h01, 8'(write_in_progress_bit));
		cfg(CFG2_CHECK_ADDR, 8'h03);
		opKind = OP_REG_READ;
		host.select();
		host.header(32'h00000200, 8'h00);
		host.get(b);
		host.resetLow();
		repeat (10) @(negedge clk);
		chk("oeReset", 8'h00, 8'(octalOe));
		chk("terminate", 8'h01, nTerm);
		host.resetHigh();
		chk("wel", 8'h00, 8'(write_enable_latch_bit));
		chk("wip", 8'h00, 8'(write_in_progress_bit));
		arrWrite(32'h00000100, 16, 8'h00, 1'b1);
		chk("boot", 8'h01, nBoot);
		arrWrite(32'h00000100, 16, 8'h00, 1'b1);
		chk("boot", 8'h01, nBoot);
		chk("active", 8'h01, 8'(parityActive));
		$display("test pin reset done");
		welSet = 1'b1;
		@(negedge clk);
		welSet = 1'b0;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk("wel", 8'h00, 8'(write_enable_latch_bit));
		chk("active", 8'h01, 8'(parityActive));
		arrWrite(32'h00000100, 16, 8'h40, 1'b0);
		chk("boot", 8'h01, nBoot);
		$display("test power cycle done");
		end_sim();
	end
endmodule
